// >>> logic/astr_pkg.sv
// Notes on behaviour
// - Pin released when both directions off; else idles high.
// - Frame is start, 8/9 bits LSB first, stop.
// - Start bit drives low, stop bit drives high.
// - Ninth transmitted bit comes from tx_ninth_bit.
// - Ninth received bit lands in rx_ninth_bit.
// - Idle character is a whole frame of ones.
// - Break frames repeat while set, then one 1 bit.
// - Enabling transmitter sends an idle frame first.
// - Toggling transmitter_on discards the held word.
// - Status read then data write clears both transmit flags.
// - Buffer empty sets on transfer; gated interrupt request.
// - Write during a frame waits in holding buffer.
// - Write while idle starts sending at once.
// - Transmit complete sets at frame end; gated interrupt.
// - receiver_on starts hunting for a start bit.
// - Completed character moves to buffer, sets full flag.
// - Status read then data read clears full flag.
// - Received break reports as framing error.
// - Idle frame raises idle flag and gated interrupt.
// - Full buffer on completion sets overrun, keeps buffer.
// - Status read then data read clears overrun, noise.
// - Samples 8, 9, 10 must agree, else noise.
// - Noise rises with full flag, no own interrupt.
// - Start samples 011/101/110 discard frame, hide noise.
// - Sixteen samples per bit, middle three voted.
// - Missing stop sets framing flag with full flag.
package astr_pkg;
   // Byte offsets of the word registers on the bus.
   localparam logic [3:0] ASTR_OFF_STATUS = 4'h0;
   localparam logic [3:0] ASTR_OFF_DATA   = 4'h4;
   localparam logic [3:0] ASTR_OFF_CTRL1  = 4'h8;
   localparam logic [3:0] ASTR_OFF_CTRL2  = 4'hc;
   // Status register bit positions.
   localparam int ASTR_ST_TX_BUFFER_EMPTY = 7;
   localparam int ASTR_ST_TC   = 6;
   localparam int ASTR_ST_RX_BUFFER_FULL = 5;
   localparam int ASTR_ST_IDLE = 4;
   localparam int ASTR_ST_OVR  = 3;
   localparam int ASTR_ST_NF   = 2;
   localparam int ASTR_ST_FE   = 1;
   // Control register one bit positions.
   localparam int ASTR_C1_RX9  = 7;
   localparam int ASTR_C1_TX9  = 6;
   localparam int ASTR_C1_WORD9 = 4;
   // Control register two bit positions.
   localparam int ASTR_C2_TIE  = 7;
   localparam int ASTR_C2_TX_COMPLETE_IRQ_EN = 6;
   localparam int ASTR_C2_RIE  = 5;
   localparam int ASTR_C2_IDLE_IRQ_EN = 4;
   localparam int ASTR_C2_TE   = 3;
   localparam int ASTR_C2_RE   = 2;
   localparam int ASTR_C2_SBK  = 0;
   // Reset values of the flags that read as set out of reset.
   localparam logic ASTR_RST_TX_BUFFER_EMPTY = 1'b1;
   localparam logic ASTR_RST_TC   = 1'b1;
   // Oversampling: sample indices are counted from zero after the edge.
   localparam logic [3:0] ASTR_PH_LAST = 4'hf;
   localparam logic [3:0] ASTR_SMP_FIRST = 4'h7;
   localparam logic [3:0] ASTR_SMP_LAST = 4'h9;
   // Frame lengths in bits and in ticks for idle line detection, and the index of the last data bit.
   localparam logic [3:0] ASTR_BITS8 = 4'ha;
   localparam logic [3:0] ASTR_BITS9 = 4'hb;
   localparam logic [7:0] ASTR_IDLE8 = 8'ha0;
   localparam logic [7:0] ASTR_IDLE9 = 8'hb0;
   localparam logic [3:0] ASTR_LAST8 = 4'h7;
   localparam logic [3:0] ASTR_LAST9 = 4'h8;
   typedef enum logic [1:0] {ASTR_RX_HUNT, ASTR_RX_START, ASTR_RX_DATA, ASTR_RX_STOP} astr_rx_t;
endpackage : astr_pkg

// >>> logic/astr_core.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module astr_core (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Baud ticks at sixteen times the bit rate, one cycle each.
   input  wire logic        tx_tick16,
   input  wire logic        rx_tick16,
   // Serial pins.
   input  wire logic        serial_rx_in,
   output logic             serial_tx_out,
   output logic             serial_tx_oe,
   // Interrupt request, gated by the processor mask.
   input  wire logic        cpu_irq_mask,
   output logic             irq_req
);
   import astr_pkg::*;

   typedef struct packed {
      // Bus data phase and registered read data.
      logic        ahb_act;
      logic        ahb_wr;
      logic [3:0]  ahb_addr;
      logic [31:0] rdata;
      // Software controls.
      logic        word9;
      logic        tx_ninth_bit;
      logic        rx_ninth_bit;
      logic        tx_empty_irq_en;
      logic        tx_complete_irq_en;
      logic        rx_irq_en;
      logic        idle_irq_en;
      logic        transmitter_on;
      logic        receiver_on;
      logic        send_break;
      // Status flags; hidden_noise waits for the next good frame.
      logic        tx_buffer_empty;
      logic        tx_complete;
      logic        rx_buffer_full;
      logic        idle_flag;
      logic        overrun_flag;
      logic        noise_flag;
      logic        framing_flag;
      logic        hidden_noise;
      logic        stat_seen;
      // Transmit path.
      logic [7:0]  tx_holding_buf;
      logic        hold_valid;
      logic        tx_busy;
      logic        tx_is_data;
      logic [10:0] tx_shift;
      logic [3:0]  tx_bits;
      logic [3:0]  tx_phase;
      logic        tx_line;
      logic        idle_pend;
      logic        brk_end_pend;
      // Receive path.
      logic        rx_sync1;
      logic        rx_sync2;
      logic        rx_prev;
      astr_rx_t    rx_state;
      logic [3:0]  rx_cnt;
      logic [3:0]  rx_bit;
      logic [2:0]  rx_samp;
      logic [8:0]  rx_shift;
      logic        rx_frame_nf;
      logic [7:0]  idle_cnt;
      logic        idle_armed;
      logic [7:0]  rx_holding_buf;
   } astr_state_t;

   astr_state_t cur_r;
   astr_state_t cur_nxt;

   // Receive vote helpers, the tick count and the bus decode.
   logic [3:0]  c;
   logic [2:0]  v;
   logic        maj;
   logic        agree;
   logic        addr_ok;
   logic        rd_data;
   logic        te_new;

   always_comb begin
      cur_nxt = cur_r;
      c = cur_r.rx_cnt + 4'h1;
      v = {cur_r.rx_samp[1:0], cur_r.rx_sync2};
      maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
      agree = (v == 3'b000) || (v == 3'b111);
      addr_ok = hsel && htrans[1] && hready;
      rd_data = addr_ok && !hwrite && (haddr[3:0] == ASTR_OFF_DATA);
      te_new = cur_r.transmitter_on;


      // Status and data register side effects, clears before sets.
      if (addr_ok && !hwrite && haddr[3:0] == ASTR_OFF_STATUS) begin
         cur_nxt.stat_seen = 1'b1;
      end
      if (rd_data) begin
         cur_nxt.stat_seen = 1'b0;
         if (cur_r.stat_seen) begin
            cur_nxt.rx_buffer_full = 1'b0;
            cur_nxt.overrun_flag = 1'b0;
            cur_nxt.noise_flag = 1'b0;
            cur_nxt.framing_flag = 1'b0;
            cur_nxt.idle_flag = 1'b0;
         end
      end


      // Transmitter: bit timing on the transmit tick.
      if (cur_r.tx_busy && tx_tick16) begin
         cur_nxt.tx_phase = cur_r.tx_phase + 4'h1;
         if (cur_r.tx_phase == ASTR_PH_LAST) begin
            cur_nxt.tx_shift = {1'b1, cur_r.tx_shift[10:1]};
            cur_nxt.tx_bits = cur_r.tx_bits - 4'h1;
            if (cur_r.tx_bits == 4'h1) begin
               cur_nxt.tx_busy = 1'b0;
               if (cur_r.tx_is_data) begin
                  cur_nxt.tx_complete = 1'b1;
               end
            end
         end
      end else if (!cur_r.tx_busy && cur_r.transmitter_on) begin
         cur_nxt.tx_phase = 4'h0;
         cur_nxt.tx_is_data = 1'b1;
         cur_nxt.tx_bits = cur_r.word9 ? ASTR_BITS9 : ASTR_BITS8;
         if (cur_r.send_break) begin
            cur_nxt.tx_busy = 1'b1;
            cur_nxt.tx_shift = 11'h000;
            cur_nxt.brk_end_pend = 1'b1;
         end else if (cur_r.brk_end_pend) begin
            // The lone mark bit lets the far end see the next start edge.
            cur_nxt.tx_busy = 1'b1;
            cur_nxt.tx_is_data = 1'b0;
            cur_nxt.tx_shift = 11'h7ff;
            cur_nxt.tx_bits = 4'h1;
            cur_nxt.brk_end_pend = 1'b0;
         end else if (cur_r.idle_pend) begin
            cur_nxt.tx_busy = 1'b1;
            cur_nxt.tx_shift = 11'h7ff;
            cur_nxt.idle_pend = 1'b0;
         end else if (cur_r.hold_valid) begin
            cur_nxt.tx_busy = 1'b1;
            cur_nxt.hold_valid = 1'b0;
            cur_nxt.tx_buffer_empty = 1'b1;
            if (cur_r.word9) begin
               cur_nxt.tx_shift = {1'b1, cur_r.tx_ninth_bit, cur_r.tx_holding_buf, 1'b0};
            end else begin
               cur_nxt.tx_shift = {2'b11, cur_r.tx_holding_buf, 1'b0};
            end
         end
      end


      // Bus write in its data phase.
      if (cur_r.ahb_act && cur_r.ahb_wr) begin
         unique case (cur_r.ahb_addr)
            ASTR_OFF_DATA: begin
               // A held word is copied out as soon as no frame is being sent.
               cur_nxt.tx_holding_buf = hwdata[7:0];
               cur_nxt.hold_valid = 1'b1;
               cur_nxt.tx_buffer_empty = 1'b0;
               cur_nxt.stat_seen = 1'b0;
               if (cur_r.stat_seen && !(cur_nxt.tx_complete && !cur_r.tx_complete)) begin
                  cur_nxt.tx_complete = 1'b0;
               end
            end
            ASTR_OFF_CTRL1: begin
               cur_nxt.word9 = hwdata[ASTR_C1_WORD9];
               cur_nxt.tx_ninth_bit = hwdata[ASTR_C1_TX9];
            end
            ASTR_OFF_CTRL2: begin
               cur_nxt.tx_empty_irq_en = hwdata[ASTR_C2_TIE];
               cur_nxt.tx_complete_irq_en = hwdata[ASTR_C2_TX_COMPLETE_IRQ_EN];
               cur_nxt.rx_irq_en = hwdata[ASTR_C2_RIE];
               cur_nxt.idle_irq_en = hwdata[ASTR_C2_IDLE_IRQ_EN];
               cur_nxt.transmitter_on = hwdata[ASTR_C2_TE];
               cur_nxt.receiver_on = hwdata[ASTR_C2_RE];
               cur_nxt.send_break = hwdata[ASTR_C2_SBK];
               te_new = hwdata[ASTR_C2_TE];
               if (te_new != cur_r.transmitter_on) begin
                  cur_nxt.hold_valid = 1'b0;
                  cur_nxt.tx_buffer_empty = 1'b1;
               end
               if (te_new && !cur_r.transmitter_on) begin
                  cur_nxt.idle_pend = 1'b1;
               end
               if (hwdata[ASTR_C2_RE] && !cur_r.receiver_on) begin
                  cur_nxt.rx_state = ASTR_RX_HUNT;
                  cur_nxt.idle_armed = 1'b1;
                  cur_nxt.idle_cnt = 8'h00;
               end
            end
            default: begin
            end
         endcase
      end
      // Between back-to-back break frames the line must not blip high.
      if (cur_nxt.tx_busy) begin
         cur_nxt.tx_line = cur_nxt.tx_shift[0];
      end else if (cur_r.tx_busy && cur_r.send_break && cur_r.transmitter_on) begin
         cur_nxt.tx_line = 1'b0;
      end else begin
         cur_nxt.tx_line = 1'b1;
      end


      // Receiver input synchroniser.
      cur_nxt.rx_sync1 = serial_rx_in;
      cur_nxt.rx_sync2 = cur_r.rx_sync1;

      // A disabled receiver drops any frame in progress.
      if (!cur_r.receiver_on) begin
         cur_nxt.rx_state = ASTR_RX_HUNT;
         cur_nxt.rx_prev = 1'b0;
      end else if (rx_tick16) begin
         cur_nxt.rx_cnt = c;
         if (c >= ASTR_SMP_FIRST && c <= ASTR_SMP_LAST) begin
            cur_nxt.rx_samp = v;
         end
         // The sample count wraps every bit; count 0 starts the next one.
         unique case (cur_r.rx_state)
            ASTR_RX_HUNT: begin
               cur_nxt.rx_prev = cur_r.rx_sync2;
               if (cur_r.rx_prev && !cur_r.rx_sync2) begin
                  // A start edge counts only after a high sample.
                  cur_nxt.rx_state = ASTR_RX_START;
                  cur_nxt.rx_cnt = 4'h0;
                  cur_nxt.rx_frame_nf = 1'b0;
                  cur_nxt.idle_cnt = 8'h00;
               end else if (!cur_r.rx_sync2) begin
                  cur_nxt.idle_cnt = 8'h00;
               end else if (cur_r.idle_armed) begin
                  cur_nxt.idle_cnt = cur_r.idle_cnt + 8'h01;
                  if (cur_nxt.idle_cnt == (cur_r.word9 ? ASTR_IDLE9 : ASTR_IDLE8)) begin
                     cur_nxt.idle_flag = 1'b1;
                     cur_nxt.idle_armed = 1'b0;
                  end
               end
            end
            ASTR_RX_START: begin
               if (c == ASTR_SMP_LAST) begin
                  if (maj) begin
                     cur_nxt.rx_state = ASTR_RX_HUNT;
                     cur_nxt.rx_prev = 1'b1;
                     if (!agree) begin
                        cur_nxt.hidden_noise = 1'b1;
                     end
                  end else if (!agree) begin
                     cur_nxt.rx_frame_nf = 1'b1;
                  end
               end
               if (c == 4'h0) begin
                  cur_nxt.rx_state = ASTR_RX_DATA;
                  cur_nxt.rx_bit = 4'h0;
               end
            end
            ASTR_RX_DATA: begin
               if (c == ASTR_SMP_LAST) begin
                  cur_nxt.rx_shift[cur_r.rx_bit] = maj;
                  if (!agree) begin
                     cur_nxt.rx_frame_nf = 1'b1;
                  end
               end
               if (c == 4'h0) begin
                  cur_nxt.rx_bit = cur_r.rx_bit + 4'h1;
                  if (cur_r.rx_bit == (cur_r.word9 ? ASTR_LAST9 : ASTR_LAST8)) begin
                     cur_nxt.rx_state = ASTR_RX_STOP;
                  end
               end
            end
            // The stop vote decides framing and ends the character.
            ASTR_RX_STOP: begin
               if (c == ASTR_SMP_LAST) begin
                  cur_nxt.rx_state = ASTR_RX_HUNT;
                  cur_nxt.rx_prev = cur_r.rx_sync2;
                  cur_nxt.idle_armed = 1'b1;
                  if (cur_r.rx_buffer_full) begin
                     cur_nxt.overrun_flag = 1'b1;
                  end else begin
                     cur_nxt.rx_buffer_full = 1'b1;
                     cur_nxt.rx_holding_buf = cur_r.rx_shift[7:0];
                     if (cur_r.word9) begin
                        cur_nxt.rx_ninth_bit = cur_r.rx_shift[8];
                     end
                     cur_nxt.noise_flag = cur_r.rx_frame_nf || !agree
                                          || cur_r.hidden_noise;
                     cur_nxt.hidden_noise = 1'b0;
                     // A break has a low stop bit and lands here too.
                     cur_nxt.framing_flag = !maj;
                  end
               end
            end
            default: begin
               cur_nxt.rx_state = ASTR_RX_HUNT;
            end
         endcase
      end


      // Address phase capture and registered read data.
      cur_nxt.ahb_act = addr_ok;
      cur_nxt.ahb_wr = hwrite;
      cur_nxt.ahb_addr = haddr[3:0];
      cur_nxt.rdata = 32'h0000_0000;
      if (addr_ok && !hwrite && haddr[31:4] == 28'h000_0000) begin
         unique case (haddr[3:0])
            ASTR_OFF_STATUS: begin
               cur_nxt.rdata[ASTR_ST_TX_BUFFER_EMPTY] = cur_r.tx_buffer_empty;
               cur_nxt.rdata[ASTR_ST_TC] = cur_r.tx_complete;
               cur_nxt.rdata[ASTR_ST_RX_BUFFER_FULL] = cur_r.rx_buffer_full;
               cur_nxt.rdata[ASTR_ST_IDLE] = cur_r.idle_flag;
               cur_nxt.rdata[ASTR_ST_OVR] = cur_r.overrun_flag;
               cur_nxt.rdata[ASTR_ST_NF] = cur_r.noise_flag;
               cur_nxt.rdata[ASTR_ST_FE] = cur_r.framing_flag;
            end
            ASTR_OFF_DATA: begin
               cur_nxt.rdata[7:0] = cur_r.rx_holding_buf;
            end
            ASTR_OFF_CTRL1: begin
               cur_nxt.rdata[ASTR_C1_RX9] = cur_r.rx_ninth_bit;
               cur_nxt.rdata[ASTR_C1_TX9] = cur_r.tx_ninth_bit;
               cur_nxt.rdata[ASTR_C1_WORD9] = cur_r.word9;
            end
            ASTR_OFF_CTRL2: begin
               cur_nxt.rdata[ASTR_C2_TIE] = cur_r.tx_empty_irq_en;
               cur_nxt.rdata[ASTR_C2_TX_COMPLETE_IRQ_EN] = cur_r.tx_complete_irq_en;
               cur_nxt.rdata[ASTR_C2_RIE] = cur_r.rx_irq_en;
               cur_nxt.rdata[ASTR_C2_IDLE_IRQ_EN] = cur_r.idle_irq_en;
               cur_nxt.rdata[ASTR_C2_TE] = cur_r.transmitter_on;
               cur_nxt.rdata[ASTR_C2_RE] = cur_r.receiver_on;
               cur_nxt.rdata[ASTR_C2_SBK] = cur_r.send_break;
            end
            default: begin
            end
         endcase
      end
   end

   // Flags that read as set come out of reset already set.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_r <= '0;
         cur_r.tx_buffer_empty <= ASTR_RST_TX_BUFFER_EMPTY;
         cur_r.tx_complete <= ASTR_RST_TC;
         cur_r.tx_line <= 1'b1;
         cur_r.tx_shift <= 11'h7ff;
         cur_r.rx_state <= ASTR_RX_HUNT;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // Every access completes at once and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = cur_r.rdata;
   assign serial_tx_out = cur_r.tx_line;
   assign serial_tx_oe = cur_r.transmitter_on | cur_r.receiver_on;
   // The mask gates every source at once.
   // Noise and framing have no term here; they ride on the full flag.
   assign irq_req = !cpu_irq_mask
                    && ((cur_r.tx_empty_irq_en && cur_r.tx_buffer_empty)
                        || (cur_r.tx_complete_irq_en && cur_r.tx_complete)
                        || (cur_r.rx_irq_en && (cur_r.rx_buffer_full || cur_r.overrun_flag))
                        || (cur_r.idle_irq_en && cur_r.idle_flag));
endmodule : astr_core
`default_nettype wire

// >>> verif/astr_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module astr_core_chk (
   // Clock and reset.
   input wire logic        ref_clk,
   input wire logic        rst,
   // Bus side.
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // Ticks, line and interrupt.
   input wire logic        tx_tick16,
   input wire logic        rx_tick16,
   input wire logic        serial_rx_in,
   input wire logic        serial_tx_out,
   input wire logic        serial_tx_oe,
   input wire logic        cpu_irq_mask,
   input wire logic        irq_req
);
   logic       rd_dp_r;
   logic [2:0] wr_age_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // The age saturates so a long quiet spell never wraps back to a recent write.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_dp_r  <= 1'b0;
         wr_age_r <= 3'h7;
      end else begin
         rd_dp_r <= hsel & htrans[1] & hready & !hwrite;
         if (hsel & htrans[1] & hready & hwrite) begin
            wr_age_r <= 3'h0;
         end else if (wr_age_r != 3'h7) begin
            wr_age_r <= wr_age_r + 3'h1;
         end
      end
   end
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
   property p_rdata_quiet;
      !rd_dp_r |-> hrdata == 32'h0;
   endproperty
   a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside data phase");
   property p_rdata_byte;
      rd_dp_r |-> hrdata[31:8] == 24'h0;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte) else $error("upper read bits not zero");
   property p_mask_blocks;
      cpu_irq_mask |-> !irq_req;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("request despite mask");
   property p_rise_on_tick;
      $rose(serial_tx_out) |-> ($past(tx_tick16) || $past(tx_tick16, 2));
   endproperty
   a_rise_on_tick: assert property (p_rise_on_tick) else $error("line rose off a tick");
   property p_start_held;
      $fell(serial_tx_out) |-> !serial_tx_out [*8];
   endproperty
   a_start_held: assert property (p_start_held) else $error("start bit too short");
   property p_fall_owned;
      $fell(serial_tx_out) |-> serial_tx_oe;
   endproperty
   a_fall_owned: assert property (p_fall_owned) else $error("line driven low while released");
   property p_oe_after_write;
      $rose(serial_tx_oe) |-> wr_age_r <= 3'h3;
   endproperty
   a_oe_after_write: assert property (p_oe_after_write) else $error("pin taken without write");
endmodule : astr_core_chk
bind astr_core astr_core_chk u_chk (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tx_tick16, .rx_tick16, .serial_rx_in,
   .serial_tx_out, .serial_tx_oe, .cpu_irq_mask, .irq_req);
`default_nettype wire

// >>> verif/astr_line_peer.sv
`timescale 1ns/1ps
`default_nettype none
module astr_line_peer (
   // Clock and ticks.
   input  wire logic ref_clk,
   input  wire logic tx_tick16,
   input  wire logic rx_tick16,
   // Serial line.
   input  wire logic serial_tx_out,
   output var logic  serial_rx_in
);
   // The far end idles at mark level between frames.
   initial serial_rx_in = 1'b1;
   task automatic ticks(input logic use_tx, input int n);
      int k;
      k = 0;
      while (k < n) begin
         @(posedge ref_clk);
         if (use_tx ? tx_tick16 : rx_tick16) k++;
      end
   endtask : ticks
   // A glitch flips only the middle of the three voted samples of bit gl.
   task automatic send(input logic [8:0] d, input int n, input logic stop, input int gl);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      f[n+1] = stop;
      // The receiver needs a high sample before the start edge counts.
      serial_rx_in <= 1'b1;
      ticks(1'b0, 2);
      for (int i = 0; i < n + 2; i++) begin
         serial_rx_in <= f[i];
         if (gl == i) begin
            ticks(1'b0, 8);
            serial_rx_in <= !f[i];
            ticks(1'b0, 1);
            serial_rx_in <= f[i];
            ticks(1'b0, 7);
         end else begin
            ticks(1'b0, 16);
         end
      end
      serial_rx_in <= 1'b1;
   endtask : send
   // Returns the data bits with the stop bit above them, sampled in mid bit.
   task automatic recv(input int n, output logic [9:0] d, output int waited);
      d = 10'h0;
      waited = 0;
      while (serial_tx_out !== 1'b0) begin
         @(posedge ref_clk);
         if (tx_tick16) waited++;
      end
      ticks(1'b1, 8);
      for (int i = 0; i <= n; i++) begin
         ticks(1'b1, 16);
         d[i] = serial_tx_out;
      end
   endtask : recv
endmodule : astr_line_peer
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import astr_pkg::*;
   logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic        tx_tick16, rx_tick16, serial_rx_in, serial_tx_out, serial_tx_oe;
   logic        cpu_irq_mask, irq_req;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, tdiv, rdiv;
   logic [2:0]  hsize;
   logic [9:0]  fr;
   int          bad_count, comparisons, cyc, w;
   assign hready = hreadyout;
   astr_core DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .tx_tick16(tx_tick16), .rx_tick16(rx_tick16),
      .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
      .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req));
   astr_line_peer peer (.ref_clk(ref_clk), .tx_tick16(tx_tick16), .rx_tick16(rx_tick16),
      .serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in));
   always #5 ref_clk = !ref_clk;
   // Different tick rates keep the two directions independent.
   always @(posedge ref_clk) begin
      tdiv <= tdiv + 2'h1;
      tx_tick16 <= (tdiv == 2'h3);
      rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
      rx_tick16 <= (rdiv == 2'h2);
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rdv = hrdata;
   endtask : bus
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      ref_clk = 0; rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
      hwdata = 0; tx_tick16 = 0; rx_tick16 = 0; cpu_irq_mask = 0; tdiv = 0; rdiv = 0;
      bad_count = 0; comparisons = 0; cyc = 0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd, 32'hc0);
      chk(serial_tx_oe, 0);
      bus(0, 8'h20, 0, rd);
      chk(rd, 0);
      fork
         peer.recv(8, fr, w);
         begin
            bus(1, ASTR_OFF_CTRL2, 32'h08, rd);
            chk(serial_tx_out, 1);
            bus(0, ASTR_OFF_STATUS, 0, rd);
            bus(1, ASTR_OFF_DATA, 32'ha5, rd);
            bus(0, ASTR_OFF_STATUS, 0, rd);
            chk(rd & 32'hc0, 0);
         end
      join
      chk(w >= 150, 1);
      chk(fr, 10'h1a5);
      peer.ticks(1, 16);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'hc0, 32'hc0);
      fork
         peer.recv(8, fr, w);
         begin
            bus(1, ASTR_OFF_DATA, 32'h3c, rd);
            bus(0, ASTR_OFF_STATUS, 0, rd);
            chk(rd & 32'hc0, 32'h80);
         end
      join
      chk(fr, 10'h13c);
      $display("transmit test done");
      bus(1, ASTR_OFF_CTRL2, 32'h2c, rd);
      peer.send(9'h096, 8, 1, -1);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h2e, 32'h20);
      chk(irq_req, 1);
      cpu_irq_mask <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(irq_req, 0);
      cpu_irq_mask <= 1'b0;
      bus(1, ASTR_OFF_DATA, 32'h55, rd);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      bus(0, ASTR_OFF_DATA, 0, rd);
      chk(rd, 32'h96);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h20, 0);
      peer.send(9'h011, 8, 1, -1);
      peer.send(9'h022, 8, 1, -1);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h2e, 32'h28);
      bus(0, ASTR_OFF_DATA, 0, rd);
      chk(rd, 32'h11);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h2e, 0);
      peer.send(9'h05a, 8, 1, 4);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h2e, 32'h24);
      bus(0, ASTR_OFF_DATA, 0, rd);
      chk(rd, 32'h5a);
      peer.send(9'h000, 8, 0, -1);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h2e, 32'h22);
      bus(0, ASTR_OFF_DATA, 0, rd);
      chk(rd, 0);
      peer.ticks(0, 180);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      chk(rd & 32'h10, 32'h10);
      $display("receive test done");
      bus(1, ASTR_OFF_CTRL1, 32'h50, rd);
      peer.send(9'h1c3, 9, 1, -1);
      bus(0, ASTR_OFF_STATUS, 0, rd);
      bus(0, ASTR_OFF_DATA, 0, rd);
      chk(rd, 32'hc3);
      bus(0, ASTR_OFF_CTRL1, 0, rd);
      chk(rd & 32'h80, 32'h80);
      fork
         peer.recv(9, fr, w);
         bus(1, ASTR_OFF_DATA, 32'h81, rd);
      join
      chk(fr, 10'h381);
      $display("nine bit test done");
      peer.ticks(1, 20);
      bus(1, ASTR_OFF_CTRL2, 32'h2d, rd);
      peer.ticks(1, 200);
      chk(serial_tx_out, 0);
      bus(1, ASTR_OFF_CTRL2, 32'h2c, rd);
      peer.ticks(1, 200);
      chk(serial_tx_out, 1);
      bus(1, ASTR_OFF_CTRL2, 32'h00, rd);
      peer.ticks(1, 20);
      chk(serial_tx_oe, 0);
      $display("break test done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
